// file: verification/memory_map_bank_decode_test.sv
/*
  Self-checking bench for the memory map and bank decode block.
  Assumes the owner model answers strobes; inputs change on falling edges.
*/
`timescale 1ns/1ns
module memory_map_bank_decode_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  mmbd_pkg::mmbd_seq_t seq_op = mmbd_pkg::SEQ_HOLD;
  logic [11:0] seq_target = 12'h000;
  logic rolling_release = 1'b0;
  logic [11:0] prog_addr_r;
  logic prog_rolling_r;
  logic da_req = 1'b0, da_write = 1'b0, da_direct = 1'b0;
  logic [6:0] da_opcode_loc = 7'h00;
  logic [7:0] da_wdata = 8'h00, status_r, fsr_r;
  logic sfr_strobe_r, sfr_write_r;
  logic [4:0] sfr_addr_r, pg_addr_r;
  logic [7:0] sfr_wdata_r, sfr_rdata, pg_wdata_r, pg_rdata;
  logic pg_req = 1'b0, pg_write = 1'b0;
  mmbd_pkg::mmbd_page_t pg_sel = mmbd_pkg::PAGE_F;
  logic [4:0] pg_addr = 5'h00;
  logic [7:0] pg_wdata = 8'h00;
  logic pg_strobe_r, pg_write_r, rd_valid_r;
  mmbd_pkg::mmbd_page_t pg_sel_r;
  logic [7:0] rd_data_r;
  mmbd_pkg::mmbd_nv_t nv_op = mmbd_pkg::NV_NONE;
  logic [7:0] nv_wdata = 8'h00;
  logic nv_flag_clr = 1'b0;
  logic nv_write_done_enable = 1'b0, global_irq_enable = 1'b0;
  logic nv_write_done_flag_r, nv_write_refused_r, nv_irq_r;
  int mismatches = 0;
  int check_count = 0;

  always #5 ref_clk = ~ref_clk;

  mmbd_map uut (.ref_clk, .rst_n, .seq_op, .seq_target, .rolling_release,
    .prog_addr_r, .prog_rolling_r, .da_req, .da_write, .da_direct,
    .da_opcode_loc, .da_wdata, .status_r, .fsr_r, .sfr_strobe_r,
    .sfr_write_r, .sfr_addr_r, .sfr_wdata_r, .sfr_rdata, .pg_req,
    .pg_write, .pg_sel, .pg_addr, .pg_wdata, .pg_strobe_r, .pg_write_r,
    .pg_sel_r, .pg_addr_r, .pg_wdata_r, .pg_rdata, .rd_valid_r,
    .rd_data_r, .nv_op, .nv_wdata, .nv_flag_clr, .nv_write_done_enable,
    .global_irq_enable, .nv_write_done_flag_r, .nv_write_refused_r,
    .nv_irq_r);

  mmbd_owner_model owner (.ref_clk, .sfr_strobe_r, .sfr_write_r,
    .sfr_addr_r, .sfr_wdata_r, .sfr_rdata, .pg_strobe_r, .pg_write_r,
    .pg_sel_r, .pg_addr_r, .pg_wdata_r, .pg_rdata);

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic check_pc(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step_seq(input mmbd_pkg::mmbd_seq_t op,
                          input logic [11:0] t);
    seq_op = op;
    seq_target = t;
    @(negedge ref_clk);
  endtask

  task automatic access(input logic wr, input logic dir,
                        input logic [6:0] loc, input logic [7:0] d);
    da_req = 1'b1;
    da_write = wr;
    da_direct = dir;
    da_opcode_loc = loc;
    da_wdata = d;
    @(negedge ref_clk);
  endtask

  // Requests stay up between back-to-back calls; this drops them
  task automatic release_all;
    da_req = 1'b0;
    pg_req = 1'b0;
    nv_op = mmbd_pkg::NV_NONE;
  endtask

  // Bounded wait: a missing answer is a mismatch, not a hang
  task automatic wait_rd(input logic [7:0] exp);
    int n;
    release_all;
    for (n = 0; n < 4 && rd_valid_r !== 1'b1; n++) @(negedge ref_clk);
    check_bit(rd_valid_r, 1'b1);
    check_byte(rd_data_r, exp);
  endtask

  task automatic page(input logic wr, input mmbd_pkg::mmbd_page_t s,
                      input logic [4:0] a, input logic [7:0] d);
    pg_req = 1'b1;
    pg_write = wr;
    pg_sel = s;
    pg_addr = a;
    pg_wdata = d;
    @(negedge ref_clk);
  endtask

  task automatic nv(input mmbd_pkg::mmbd_nv_t op, input logic [7:0] d);
    nv_op = op;
    nv_wdata = d;
    @(negedge ref_clk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int i;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    check_pc(prog_addr_r, mmbd_pkg::VEC_RESET);
    // Targets stay clear of the two reserved top words
    step_seq(mmbd_pkg::SEQ_STEP, 12'h000);
    check_pc(prog_addr_r, 12'h001);
    step_seq(mmbd_pkg::SEQ_FAR_JUMP, 12'ha40);
    check_pc(prog_addr_r, 12'ha40);
    step_seq(mmbd_pkg::SEQ_SHORT_JUMP, 12'h0c5);
    check_pc(prog_addr_r, 12'hac5);
    step_seq(mmbd_pkg::SEQ_FAR_CALL, 12'h123);
    check_pc(prog_addr_r, 12'h123);
    step_seq(mmbd_pkg::SEQ_SWI, 12'h000);
    check_pc(prog_addr_r, mmbd_pkg::VEC_SWI);
    step_seq(mmbd_pkg::SEQ_HWI, 12'h000);
    check_pc(prog_addr_r, mmbd_pkg::VEC_HWI);
    step_seq(mmbd_pkg::SEQ_RETURN, 12'h000);
    check_pc(prog_addr_r, 12'h002);
    step_seq(mmbd_pkg::SEQ_RETURN, 12'h000);
    check_pc(prog_addr_r, 12'h124);
    step_seq(mmbd_pkg::SEQ_SHORT_CALL, 12'h0ff);
    check_pc(prog_addr_r, 12'h1ff);
    step_seq(mmbd_pkg::SEQ_RETURN, 12'h000);
    check_pc(prog_addr_r, 12'h125);
    step_seq(mmbd_pkg::SEQ_FAR_CALL, 12'h3a0);
    check_pc(prog_addr_r, 12'h3a0);
    step_seq(mmbd_pkg::SEQ_RETURN, 12'h000);
    check_pc(prog_addr_r, 12'h126);
    step_seq(mmbd_pkg::SEQ_FAR_JUMP, mmbd_pkg::ROLL_LO);
    step_seq(mmbd_pkg::SEQ_HOLD, 12'h000);
    check_bit(prog_rolling_r, 1'b1);
    rolling_release = 1'b1;
    @(negedge ref_clk);
    rolling_release = 1'b0;
    step_seq(mmbd_pkg::SEQ_STEP, 12'h000);
    step_seq(mmbd_pkg::SEQ_HOLD, 12'h000);
    check_bit(prog_rolling_r, 1'b0);
    $display("test program sequencing done");

    check_byte(status_r, mmbd_pkg::STATUS_RST);
    access(1'b1, 1'b1, 7'h02, 8'h5a);
    check_pc(prog_addr_r, 12'h05a);
    access(1'b0, 1'b1, 7'h02, 8'h00);
    wait_rd(8'h5a);
    access(1'b1, 1'b1, 7'h50, 8'h11);
    access(1'b1, 1'b1, 7'h30, 8'h33);
    access(1'b1, 1'b1, 7'h03, 8'h40);
    check_byte(status_r, 8'h40);
    access(1'b1, 1'b1, 7'h50, 8'h22);
    access(1'b0, 1'b1, 7'h30, 8'h00);
    wait_rd(8'h33);
    access(1'b0, 1'b1, 7'h50, 8'h00);
    wait_rd(8'h22);
    access(1'b1, 1'b1, 7'h04, 8'hd0);
    check_byte(fsr_r, 8'hd0);
    access(1'b0, 1'b0, 7'h00, 8'h00);
    wait_rd(8'h22);
    access(1'b0, 1'b1, 7'h00, 8'h00);
    wait_rd(8'h22);
    access(1'b1, 1'b1, 7'h03, 8'h00);
    access(1'b0, 1'b1, 7'h50, 8'h00);
    wait_rd(8'h11);
    access(1'b1, 1'b1, 7'h03, 8'h80);
    access(1'b1, 1'b1, 7'h05, 8'h6b);
    access(1'b1, 1'b1, 7'h03, 8'hc0);
    check_byte(status_r, 8'hc0);
    access(1'b0, 1'b1, 7'h05, 8'h00);
    wait_rd(8'h6b);
    $display("test data banks done");

    for (i = 0; i < 3; i++)
      page(1'b1, mmbd_pkg::mmbd_page_t'(i), 5'h07 + 5'(i), 8'h80 + 8'(i));
    for (i = 0; i < 3; i++) begin
      page(1'b0, mmbd_pkg::mmbd_page_t'(i), 5'h07 + 5'(i), 8'h00);
      wait_rd(8'h80 + 8'(i));
    end
    $display("test auxiliary pages done");

    nv(mmbd_pkg::NV_ADDR_WRITE, 8'h45);
    nv(mmbd_pkg::NV_DATA_WRITE, 8'h23);
    nv(mmbd_pkg::NV_STORE_WRITE, 8'h00);
    check_bit(nv_write_refused_r, 1'b1);
    check_bit(nv_write_done_flag_r, 1'b0);
    nv_write_done_enable = 1'b1;
    global_irq_enable = 1'b1;
    nv(mmbd_pkg::NV_KEY_LOAD, mmbd_pkg::KEY_1);
    nv(mmbd_pkg::NV_KEY_LOAD, mmbd_pkg::KEY_2);
    nv(mmbd_pkg::NV_KEY_LOAD, mmbd_pkg::KEY_3);
    nv(mmbd_pkg::NV_STORE_WRITE, 8'h00);
    check_bit(nv_write_done_flag_r, 1'b1);
    check_bit(nv_write_refused_r, 1'b0);
    release_all;
    @(negedge ref_clk);
    check_bit(nv_irq_r, 1'b1);
    nv(mmbd_pkg::NV_STORE_WRITE, 8'h00);
    check_bit(nv_write_refused_r, 1'b1);
    nv_flag_clr = 1'b1;
    @(negedge ref_clk);
    nv_flag_clr = 1'b0;
    check_bit(nv_write_done_flag_r, 1'b0);
    nv(mmbd_pkg::NV_KEY_LOAD, mmbd_pkg::KEY_1);
    nv(mmbd_pkg::NV_KEY_LOAD, mmbd_pkg::KEY_2);
    nv(mmbd_pkg::NV_KEY_LOAD, 8'h55);
    nv(mmbd_pkg::NV_KEY_LOAD, mmbd_pkg::KEY_3);
    nv(mmbd_pkg::NV_STORE_WRITE, 8'h00);
    check_bit(nv_write_refused_r, 1'b1);
    nv(mmbd_pkg::NV_DATA_WRITE, 8'h00);
    nv(mmbd_pkg::NV_STORE_READ, 8'h00);
    repeat (2) @(negedge ref_clk);
    nv(mmbd_pkg::NV_DATA_READ, 8'h00);
    wait_rd(8'h23);
    nv(mmbd_pkg::NV_ADDR_READ, 8'h00);
    wait_rd(8'h45);
    $display("test nonvolatile store done");
    finish_test;
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Tests take about 100 cycles; far beyond that means a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    finish_test;
  end
endmodule

// file: verification/mmbd_owner_model.sv
/*
  Owner model for the special registers and the three auxiliary pages.
  Assumes one clock and that the block raises one owner strobe per cycle.
*/
`timescale 1ns/1ns
module mmbd_owner_model (
  // Clock
  input wire logic ref_clk,
  // Special register strobe
  input wire logic sfr_strobe_r,
  input wire logic sfr_write_r,
  input wire logic [4:0] sfr_addr_r,
  input wire logic [7:0] sfr_wdata_r,
  output logic [7:0] sfr_rdata,
  // Page strobe
  input wire logic pg_strobe_r,
  input wire logic pg_write_r,
  input wire mmbd_pkg::mmbd_page_t pg_sel_r,
  input wire logic [4:0] pg_addr_r,
  input wire logic [7:0] pg_wdata_r,
  output logic [7:0] pg_rdata
);
  logic [7:0] sfr_mem [32];
  logic [7:0] pg_mem [128];
  logic [7:0] sfr_last = 8'h00;
  logic [7:0] pg_last = 8'h00;
  // Unselected owners show the inverse of the last value, never a stale copy
  assign sfr_rdata = sfr_strobe_r ? sfr_mem[sfr_addr_r] : ~sfr_last;
  assign pg_rdata = pg_strobe_r ? pg_mem[{pg_sel_r, pg_addr_r}] : ~pg_last;
  always @(posedge ref_clk) begin
    if (sfr_strobe_r) begin
      if (sfr_write_r) sfr_mem[sfr_addr_r] <= sfr_wdata_r;
      sfr_last <= sfr_rdata;
    end
    if (pg_strobe_r) begin
      if (pg_write_r) pg_mem[{pg_sel_r, pg_addr_r}] <= pg_wdata_r;
      pg_last <= pg_rdata;
    end
  end
endmodule

// file: verilog/mmbd_map.sv
/*
  Program counter, call stack, banked data decode, auxiliary page access
  and nonvolatile store register path of a small 8-bit controller.
  Assumes the core issues at most one op per group each cycle and that
  external register owners answer in the cycle their strobe is high.
*/
`timescale 1ns/1ns
module mmbd_map #(
  parameter int STACK_DEPTH = 8,
  parameter int NV_DEPTH_AW = mmbd_pkg::NV_AW
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Program sequencing
  input wire mmbd_pkg::mmbd_seq_t seq_op,
  input wire logic [11:0] seq_target,
  input wire logic rolling_release,
  output logic [11:0] prog_addr_r,
  output logic prog_rolling_r,
  // Data access
  input wire logic da_req,
  input wire logic da_write,
  input wire logic da_direct,
  input wire logic [6:0] da_opcode_loc,
  input wire logic [7:0] da_wdata,
  output logic [7:0] status_r,
  output logic [7:0] fsr_r,
  // Special register strobe to owners
  output logic sfr_strobe_r,
  output logic sfr_write_r,
  output logic [4:0] sfr_addr_r,
  output logic [7:0] sfr_wdata_r,
  input wire logic [7:0] sfr_rdata,
  // Auxiliary pages
  input wire logic pg_req,
  input wire logic pg_write,
  input wire mmbd_pkg::mmbd_page_t pg_sel,
  input wire logic [4:0] pg_addr,
  input wire logic [7:0] pg_wdata,
  output logic pg_strobe_r,
  output logic pg_write_r,
  output mmbd_pkg::mmbd_page_t pg_sel_r,
  output logic [4:0] pg_addr_r,
  output logic [7:0] pg_wdata_r,
  input wire logic [7:0] pg_rdata,
  // Read answer
  output logic rd_valid_r,
  output logic [7:0] rd_data_r,
  // Nonvolatile store
  input wire mmbd_pkg::mmbd_nv_t nv_op,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_flag_clr,
  input wire logic nv_write_done_enable,
  input wire logic global_irq_enable,
  output logic nv_write_done_flag_r,
  output logic nv_write_refused_r,
  output logic nv_irq_r
);
  // ----------------------------------------
  // Program counter and stack
  // ----------------------------------------
  localparam int SP_W = $clog2(STACK_DEPTH);
  logic [11:0] stack_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [11:0] pc_nxt;
  logic [11:0] ret_addr;
  logic push;
  logic pop;
  logic rolling_locked_r;
  logic pcl_wr;

  assign ret_addr = prog_addr_r + 12'h001;
  assign push = seq_op inside {mmbd_pkg::SEQ_SHORT_CALL,
    mmbd_pkg::SEQ_FAR_CALL, mmbd_pkg::SEQ_SWI, mmbd_pkg::SEQ_HWI};
  assign pop = (seq_op == mmbd_pkg::SEQ_RETURN);

  always_comb begin
    pc_nxt = prog_addr_r;
    unique case (seq_op)
      mmbd_pkg::SEQ_HOLD: pc_nxt = prog_addr_r;
      mmbd_pkg::SEQ_STEP: pc_nxt = ret_addr;
      // Short forms stay in the current 256-word page
      mmbd_pkg::SEQ_SHORT_JUMP, mmbd_pkg::SEQ_SHORT_CALL: begin
        pc_nxt = {prog_addr_r[11:8], seq_target[7:0]};
      end
      mmbd_pkg::SEQ_FAR_JUMP, mmbd_pkg::SEQ_FAR_CALL: begin
        pc_nxt = seq_target;
      end
      mmbd_pkg::SEQ_RETURN: pc_nxt = stack_r[sp_r - 1'b1];
      mmbd_pkg::SEQ_SWI: pc_nxt = mmbd_pkg::VEC_SWI;
      mmbd_pkg::SEQ_HWI: pc_nxt = mmbd_pkg::VEC_HWI;
      default: pc_nxt = prog_addr_r;
    endcase
    // A low-byte write acts as a computed jump when sequencing holds or steps
    if (pcl_wr && seq_op inside {mmbd_pkg::SEQ_HOLD,
        mmbd_pkg::SEQ_STEP}) begin
      pc_nxt = {prog_addr_r[11:8], da_wdata};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr_r <= mmbd_pkg::VEC_RESET;
    end else begin
      prog_addr_r <= pc_nxt;
    end
  end

  // Stack wraps on overflow; the oldest entry is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= '0;
    end else if (push) begin
      sp_r <= sp_r + 1'b1;
    end else if (pop) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      stack_r[sp_r] <= ret_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rolling_locked_r <= 1'b1;
      prog_rolling_r <= 1'b0;
    end else begin
      if (rolling_release) begin
        rolling_locked_r <= 1'b0;
      end
      prog_rolling_r <= rolling_locked_r && !rolling_release &&
        (pc_nxt == mmbd_pkg::ROLL_LO || pc_nxt == mmbd_pkg::ROLL_HI);
    end
  end

  // ----------------------------------------
  // Banked data decode
  // ----------------------------------------
  logic [6:0] loc;
  logic [1:0] bank;
  logic [1:0] eff_bank;
  logic is_sfr;
  logic [8:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [7:0] reg_val;

  assign bank = status_r[mmbd_pkg::BANK_HI:mmbd_pkg::BANK_LO];

  always_comb begin
    loc = da_direct ? da_opcode_loc : fsr_r[6:0];
    if (da_direct && da_opcode_loc == mmbd_pkg::ADDR_INDIRECT) begin
      loc = fsr_r[6:0];
    end
  end

  assign is_sfr = (loc <= mmbd_pkg::SFR_LAST);
  // Shared area and special registers fold onto bank 0
  assign eff_bank = (loc <= mmbd_pkg::SHARED_LAST) ? 2'b00 : bank;
  assign ram_addr = {eff_bank, loc};
  assign ram_we = da_req && da_write && !is_sfr;
  assign pcl_wr = da_req && da_write && loc == mmbd_pkg::ADDR_PCL;

  mmbd_ram #(.AW(mmbd_pkg::RAM_AW), .DW(8)) u_gpr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(da_wdata),
    .rdata(ram_rdata)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= mmbd_pkg::STATUS_RST;
      fsr_r <= mmbd_pkg::FSR_RST;
    end else if (da_req && da_write) begin
      if (loc == mmbd_pkg::ADDR_STATUS) begin
        status_r <= da_wdata;
      end
      if (loc == mmbd_pkg::ADDR_FSR) begin
        fsr_r <= da_wdata;
      end
    end
  end

  always_comb begin
    unique case (loc)
      mmbd_pkg::ADDR_PCL: reg_val = prog_addr_r[7:0];
      mmbd_pkg::ADDR_STATUS: reg_val = status_r;
      mmbd_pkg::ADDR_FSR: reg_val = fsr_r;
      default: reg_val = 8'h00;
    endcase
  end

  // Owners of the special registers above FSR see one strobe per access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_strobe_r <= 1'b0;
      sfr_write_r <= 1'b0;
      sfr_addr_r <= '0;
      sfr_wdata_r <= '0;
    end else begin
      sfr_strobe_r <= da_req && is_sfr && loc > mmbd_pkg::ADDR_FSR;
      sfr_write_r <= da_write;
      sfr_addr_r <= loc[4:0];
      sfr_wdata_r <= da_wdata;
    end
  end

  // ----------------------------------------
  // Auxiliary pages
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_strobe_r <= 1'b0;
      pg_write_r <= 1'b0;
      pg_sel_r <= mmbd_pkg::PAGE_F;
      pg_addr_r <= '0;
      pg_wdata_r <= '0;
    end else begin
      pg_strobe_r <= pg_req;
      pg_write_r <= pg_write;
      pg_sel_r <= pg_sel;
      pg_addr_r <= pg_addr;
      pg_wdata_r <= pg_wdata;
    end
  end

  // ----------------------------------------
  // Nonvolatile store
  // ----------------------------------------
  logic [7:0] nv_addr_r;
  logic [7:0] nv_data_r;
  logic [7:0] nv_rdata;
  mmbd_pkg::mmbd_key_t key_r;
  logic nv_rd_pend_r;
  logic nv_wr_ok;
  logic flag_nxt;

  assign nv_wr_ok = nv_op == mmbd_pkg::NV_STORE_WRITE &&
    key_r == mmbd_pkg::KEY_OPEN;

  mmbd_ram #(.AW(NV_DEPTH_AW), .DW(8)) u_nv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(nv_wr_ok),
    .addr(nv_addr_r[NV_DEPTH_AW-1:0]),
    .wdata(nv_data_r),
    .rdata(nv_rdata)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_addr_r <= mmbd_pkg::NV_REG_RST;
    end else if (nv_op == mmbd_pkg::NV_ADDR_WRITE) begin
      nv_addr_r <= nv_wdata;
    end
  end

  // Store read lands one cycle late because the array read is registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_data_r <= mmbd_pkg::NV_REG_RST;
      nv_rd_pend_r <= 1'b0;
    end else begin
      nv_rd_pend_r <= (nv_op == mmbd_pkg::NV_STORE_READ);
      if (nv_rd_pend_r) begin
        nv_data_r <= nv_rdata;
      end else if (nv_op == mmbd_pkg::NV_DATA_WRITE) begin
        nv_data_r <= nv_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_r <= mmbd_pkg::KEY_LOCKED;
    end else if (nv_op == mmbd_pkg::NV_STORE_WRITE) begin
      key_r <= mmbd_pkg::KEY_LOCKED;
    end else if (nv_op == mmbd_pkg::NV_KEY_LOAD) begin
      unique case (key_r)
        mmbd_pkg::KEY_GOT1: key_r <= (nv_wdata == mmbd_pkg::KEY_2) ?
          mmbd_pkg::KEY_GOT2 : mmbd_pkg::KEY_LOCKED;
        mmbd_pkg::KEY_GOT2: key_r <= (nv_wdata == mmbd_pkg::KEY_3) ?
          mmbd_pkg::KEY_OPEN : mmbd_pkg::KEY_LOCKED;
        // From locked or open, the first code starts the sequence; any other value locks
        default: key_r <= (nv_wdata == mmbd_pkg::KEY_1) ?
          mmbd_pkg::KEY_GOT1 : mmbd_pkg::KEY_LOCKED;
      endcase
    end
  end

  // Set wins over a clear in the same cycle
  assign flag_nxt = nv_wr_ok || (nv_write_done_flag_r && !nv_flag_clr);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_write_done_flag_r <= 1'b0;
      nv_write_refused_r <= 1'b0;
      nv_irq_r <= 1'b0;
    end else begin
      nv_write_done_flag_r <= flag_nxt;
      nv_write_refused_r <= nv_op == mmbd_pkg::NV_STORE_WRITE && !nv_wr_ok;
      nv_irq_r <= flag_nxt && nv_write_done_enable &&
        global_irq_enable;
    end
  end

  // ----------------------------------------
  // Read answer, two cycles after the request
  // ----------------------------------------
  mmbd_pkg::mmbd_src_t src_r;
  logic [7:0] reg_val_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= mmbd_pkg::SRC_NONE;
      reg_val_r <= '0;
    end else begin
      src_r <= mmbd_pkg::SRC_NONE;
      reg_val_r <= reg_val;
      if (da_req && !da_write) begin
        src_r <= !is_sfr ? mmbd_pkg::SRC_RAM :
          (loc > mmbd_pkg::ADDR_FSR) ? mmbd_pkg::SRC_EXT :
          mmbd_pkg::SRC_REG;
      end else if (pg_req && !pg_write) begin
        src_r <= mmbd_pkg::SRC_PAGE;
      end else if (nv_op == mmbd_pkg::NV_ADDR_READ) begin
        src_r <= mmbd_pkg::SRC_REG;
        reg_val_r <= nv_addr_r;
      end else if (nv_op == mmbd_pkg::NV_DATA_READ) begin
        src_r <= mmbd_pkg::SRC_REG;
        reg_val_r <= nv_data_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= (src_r != mmbd_pkg::SRC_NONE);
      unique case (src_r)
        mmbd_pkg::SRC_RAM: rd_data_r <= ram_rdata;
        mmbd_pkg::SRC_EXT: rd_data_r <= sfr_rdata;
        mmbd_pkg::SRC_PAGE: rd_data_r <= pg_rdata;
        mmbd_pkg::SRC_REG: rd_data_r <= reg_val_r;
        default: rd_data_r <= rd_data_r;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_call;
    seq_op == mmbd_pkg::SEQ_FAR_CALL;
  endsequence
  sequence s_key_ok;
    nv_op == mmbd_pkg::NV_KEY_LOAD && nv_wdata == mmbd_pkg::KEY_1 ##1
    nv_op == mmbd_pkg::NV_KEY_LOAD && nv_wdata == mmbd_pkg::KEY_2 ##1
    nv_op == mmbd_pkg::NV_KEY_LOAD && nv_wdata == mmbd_pkg::KEY_3;
  endsequence

  a_hard_vector: assert property (seq_op == mmbd_pkg::SEQ_HWI |=>
    prog_addr_r == mmbd_pkg::VEC_HWI) else $error("bad hard vector");
  a_short_page: assert property (seq_op == mmbd_pkg::SEQ_SHORT_JUMP |=>
    prog_addr_r[11:8] == $past(prog_addr_r[11:8]) &&
    prog_addr_r[7:0] == $past(seq_target[7:0]))
    else $error("short jump left page");
  a_call_return: assert property (s_call ##1
    seq_op == mmbd_pkg::SEQ_RETURN |=>
    prog_addr_r == $past(prog_addr_r, 2) + 12'h001)
    else $error("return address wrong");
  a_shared_bank: assert property (da_req && loc <= mmbd_pkg::SHARED_LAST
    |-> ram_addr[8:7] == 2'b00) else $error("shared area not bank 0");
  a_own_bank: assert property (da_req && loc > mmbd_pkg::SHARED_LAST
    |-> ram_addr == {status_r[7:6], loc}) else $error("bank wrong");
  a_page_pass: assert property (pg_req |=> pg_strobe_r &&
    pg_addr_r == $past(pg_addr)) else $error("page access lost");
  a_key_unlock: assert property (s_key_ok |=> key_r == mmbd_pkg::KEY_OPEN)
    else $error("key sequence refused");
  a_key_relock: assert property (nv_op == mmbd_pkg::NV_STORE_WRITE |=>
    key_r == mmbd_pkg::KEY_LOCKED ##0 nv_write_done_flag_r ==
    $past(key_r == mmbd_pkg::KEY_OPEN ||
    (nv_write_done_flag_r && !nv_flag_clr)))
    else $error("store write lock or flag wrong");
  a_read_lat: assert property (da_req && !da_write |=> ##1 rd_valid_r)
    else $error("read answer late");
endmodule

// file: verilog/mmbd_pkg.sv
/*
  Shared constants and types of the memory map and bank decode block.
  Assumes a single 100 MHz core clock and an active low async reset.
*/
package mmbd_pkg;
  // ----------------------------------------
  // Program space
  // ----------------------------------------
  localparam int PC_W = 12;
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_SWI = 12'h001;
  localparam logic [11:0] VEC_HWI = 12'h008;
  localparam logic [11:0] ROLL_LO = 12'h00e;
  localparam logic [11:0] ROLL_HI = 12'h00f;
  localparam logic [11:0] RSVD_LO = 12'hffe;
  // ----------------------------------------
  // Data space
  // ----------------------------------------
  localparam int LOC_W = 7;
  localparam int BANK_HI = 7;
  localparam int BANK_LO = 6;
  localparam int RAM_AW = 9;
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PCL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_FSR = 7'h04;
  localparam logic [6:0] SFR_LAST = 7'h1f;
  localparam logic [6:0] SHARED_LAST = 7'h3f;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] FSR_RST = 8'h00;
  // ----------------------------------------
  // Nonvolatile store
  // ----------------------------------------
  localparam int NV_AW = 7;
  localparam logic [7:0] NV_REG_RST = 8'h00;
  localparam logic [7:0] KEY_1 = 8'hc9;
  localparam logic [7:0] KEY_2 = 8'h3a;
  localparam logic [7:0] KEY_3 = 8'hd3;

  typedef enum logic [3:0] {SEQ_HOLD, SEQ_STEP, SEQ_SHORT_JUMP,
    SEQ_SHORT_CALL, SEQ_FAR_JUMP, SEQ_FAR_CALL, SEQ_RETURN, SEQ_SWI,
    SEQ_HWI} mmbd_seq_t;
  typedef enum logic [1:0] {PAGE_F, PAGE_S, PAGE_T} mmbd_page_t;
  typedef enum logic [2:0] {NV_NONE, NV_ADDR_READ, NV_ADDR_WRITE,
    NV_DATA_READ, NV_DATA_WRITE, NV_STORE_READ, NV_STORE_WRITE,
    NV_KEY_LOAD} mmbd_nv_t;
  typedef enum logic [1:0] {KEY_LOCKED, KEY_GOT1, KEY_GOT2,
    KEY_OPEN} mmbd_key_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_RAM, SRC_REG, SRC_EXT,
    SRC_PAGE} mmbd_src_t;
endpackage

// file: verilog/mmbd_ram.sv
/*
  Single port synchronous RAM with a registered read port.
  Assumes one clock; contents are not reset.
*/
`timescale 1ns/1ns
module mmbd_ram #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read data is the old word on a write cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule
